//--- include/lpm_pkg.sv
/*
 * constants, types and field layouts for the operating-mode and low-power controller.
 * assumes one 50 MHz system clock and a cpu core that reports its cycle status each clock.
 */
package lpm_pkg;

    // operating mode control register
    localparam logic [7:0] OPERATING_MODE_CONTROL_ADDR      = 8'h3E;  // i/o address of the register
    localparam logic [7:0] OPERATING_MODE_CONTROL_RESET     = 8'h80;  // value after reset, fetch marker on
    localparam int         FME_BIT        = 7;      // fetch_marker_enable position

    // cycle counts
    localparam int         QUICK_RESTART_CYCLES = 64;     // quick recovery restart
    localparam int         SLOW_RESTART_CYCLES  = 131072; // full oscillator restart
    localparam int         IDLE_GRANT_EXTRA     = 8;      // extra grant latency in idle
    localparam int         INTERRUPT_RETURN_INSTRUCTION_FETCH_CYCLES    = 3;      // single return fetch, zero wait

    // fixed nonmaskable vector
    localparam logic [15:0] NMI_VECTOR    = 16'h0066;

    // one-hot operating states
    typedef enum logic [7:0] {
        ST_RUN        = 8'h01,  // normal execution
        ST_HALT       = 8'h02,  // halt, clocks running
        ST_SLEEP      = 8'h04,  // core and dma clocks blocked
        ST_IDLE       = 8'h08,  // system clock output stopped
        ST_STANDBY    = 8'h10,  // oscillator stopped
        ST_RESTART    = 8'h20,  // clock stabilisation count
        ST_GRANT_WAIT = 8'h40,  // low-power bus grant latency
        ST_GRANTED    = 8'h80   // bus held by external master
    } lpm_state_t;

    // cycle status reported by the cpu core
    typedef struct packed {
        logic        opcode_fetch;   // opcode fetch cycle in progress
        logic        int_ack;        // interrupt acknowledge cycle
        logic        nmi_ack_first;  // first machine cycle of nmi acknowledge
        logic        interrupt_return_instruction_fetched;   // interrupt_return_instruction just fetched
        logic        interrupt_return_instruction_refetch;   // legacy refetch cycle of the return instruction
        logic        insn_end;       // last cycle of an instruction
        logic        halt_exec;      // halt instruction executed
        logic        sleep_exec;     // sleep_instruction executed
        logic [15:0] next_pc;        // address of the following instruction
    } core_status_t;

    // cpu and i/o control bits owned by other registers
    typedef struct packed {
        logic io_freeze_bit;              // i/o stop
        logic quick_recovery_select;      // cpu control bit 3
        logic lowpower_bus_grant_enable;  // cpu control bit 5
        logic cpu_control_bit_six;        // cpu control bit 6
    } cpu_control_t;

endpackage : lpm_pkg

//--- logic/cpu_low_power_mode_control.sv
/*
 * operating-mode and low-power controller: fetch marker strobe, halt, sleep, idle
 * and standby entry and wake-up, and low-power bus grant to an external master.
 * assumes the core reports cycle status on the same clock and obeys the clock enables,
 * and that pins (interrupts, nmi, bus request) are asynchronous and active low.
 */
// How it works
// - reset sets fetch marker enable to one
// - marker on: strobe low on fetch/ack
// - marker on: return instruction fetched once
// - marker off: strobe only on legacy refetch
// - halt exits on reset, nmi, enabled interrupts
// - halt return address is next instruction
// - sleep when freeze and bits 3,6 zero
// - sleep gates core/dma clocks, stops refresh
// - sleep holds bus high, halt indicator low
// - sleep wakes on nmi or enabled sources
// - sleep wake with flag one takes interrupt
// - sleep wake with flag zero just continues
// - idle grants bus eight cycles later, if enabled
// - idle bus release stops clock, stays idle
// - standby wake takes interrupt when allowed
// - standby wake flag zero continues after sleep
// - request dropped during restart: stay standby
// - standby restart 64 or 131072 clocks
// - standby bus grant 64 or 131072 clocks
// - halt indicator low while waiting for wake
// - nmi taken at instruction end, vector 0066
module cpu_low_power_mode_control #(
    parameter int ONCHIP_SOURCES      = 4,                           // on-chip interrupt lines
    parameter int SLOW_RESTART_CYCLES = lpm_pkg::SLOW_RESTART_CYCLES // slow restart count
) (
    input  wire logic                        mclk_i,                 // 50 MHz system clock
    input  wire logic                        srst_i,                 // synchronous reset
    input  wire logic                        ce_i,                   // clock enable
    input  wire logic [7:0]                  io_addr_i,              // i/o address
    input  wire logic                        io_wr_i,                // i/o write strobe
    input  wire logic                        io_rd_i,                // i/o read strobe
    input  wire logic [7:0]                  io_wdata_i,             // i/o write data
    output logic      [7:0]                  io_rdata_o,             // i/o read data
    input  wire lpm_pkg::core_status_t       core_i,                 // core cycle status
    input  wire lpm_pkg::cpu_control_t       ctrl_i,                 // control bits
    input  wire logic                        global_interrupt_flag_i,// interrupts enabled
    input  wire logic [ONCHIP_SOURCES-1:0]   onchip_req_i,           // on-chip requests
    input  wire logic [ONCHIP_SOURCES-1:0]   onchip_en_i,            // on-chip enables
    input  wire logic [2:0]                  maskable_en_i,          // external enables
    input  wire logic [2:0]                  maskable_request_n_i,   // external pins
    input  wire logic                        nmi_n_i,                // nmi pin, falling edge
    input  wire logic                        bus_request_n_i,        // bus request pin
    output logic                             first_cycle_strobe_n_o, // first-cycle strobe
    output logic                             halt_n_o,               // halt indicator
    output logic                             bus_ack_n_o,            // bus acknowledge
    output logic                             core_clock_en_o,        // core clock gate
    output logic                             dma_clock_en_o,         // dma clock gate
    output logic                             system_clock_run_o,     // clock output runs
    output logic                             refresh_en_o,           // memory refresh runs
    output logic                             bus_hold_high_o,        // address/control high
    output logic                             resume_o,               // leave low power
    output logic                             take_interrupt_o,       // service interrupt
    output logic                             nmi_take_o,             // nmi taken now
    output logic      [15:0]                 vector_o,               // nmi vector
    output logic      [15:0]                 resume_pc_o,            // saved return address
    output logic                             interrupt_return_instruction_refetch_o,         // request legacy refetch
    output logic                             fetch_marker_enable_o   // current marker bit
);
    import lpm_pkg::*;

    localparam int CNT_W = $clog2(SLOW_RESTART_CYCLES + 1);  // restart counter width

    // refuse values the counter cannot serve
    if (ONCHIP_SOURCES < 1 || SLOW_RESTART_CYCLES < QUICK_RESTART_CYCLES) begin : g_bad
        $error("cpu_low_power_mode_control: bad parameters");
    end

    // registers
    logic [7:0]        operating_mode_control_q;          // operating mode control
    lpm_state_t        state_q;         // current state
    lpm_state_t        state_d;         // next state
    lpm_state_t        ret_q;           // low-power state to return to after a grant
    lpm_state_t        ret_d;           // next return state
    logic [CNT_W-1:0]  cnt_q;           // stabilisation / grant count
    logic [CNT_W-1:0]  cnt_d;           // next count
    logic [2:0]        mreq_s1_q;       // synchroniser stage one
    logic [2:0]        mreq_s2_q;       // synchroniser stage two
    logic [1:0]        misc_s1_q;       // nmi, bus request stage one
    logic [1:0]        misc_s2_q;       // nmi, bus request stage two
    logic              nmi_old_q;       // previous nmi level for the edge
    logic              nmi_pend_q;      // latched nmi edge
    logic              strobe_n_q;      // registered strobe
    logic              bus_ack_q;       // registered acknowledge
    logic              resume_q;        // resume pulse
    logic              take_q;          // take interrupt pulse
    logic              nmi_take_q;      // nmi taken pulse
    logic [15:0]       vector_q;        // vector output
    logic [15:0]       resume_pc_q;     // saved return address

    // decoded wires
    wire operating_mode_control_hit   = (io_addr_i == OPERATING_MODE_CONTROL_ADDR);
    wire operating_mode_control_wr    = ce_i & io_wr_i & operating_mode_control_hit;
    wire fme        = operating_mode_control_q[FME_BIT];
    wire nmi_lvl    = misc_s2_q[0];
    wire req_act    = ~misc_s2_q[1];                           // bus request active
    wire nmi_edge   = nmi_old_q & ~nmi_lvl;                    // falling edge
    wire [2:0] mask_act = ~mreq_s2_q & maskable_en_i;
    wire ext_wake   = |mask_act;
    wire chip_wake  = |(onchip_req_i & onchip_en_i);
    wire nmi_any    = nmi_pend_q | nmi_edge;
    wire wake_any   = nmi_any | ext_wake | chip_wake;
    wire take_int   = nmi_any | (global_interrupt_flag_i & (ext_wake | chip_wake));
    wire st_run     = (state_q == ST_RUN);
    wire waiting    = (state_q == ST_HALT) | (state_q == ST_SLEEP) |
                      (state_q == ST_IDLE) | (state_q == ST_STANDBY);
    wire cnt_done   = (cnt_q == '0);
    wire nmi_run    = st_run & core_i.insn_end & nmi_any;
    wire sleep_mode = ~ctrl_i.io_freeze_bit & ~ctrl_i.quick_recovery_select &
                      ~ctrl_i.cpu_control_bit_six;
    wire stby_mode  = ctrl_i.io_freeze_bit & ctrl_i.cpu_control_bit_six;
    wire lp_grant   = req_act & ctrl_i.lowpower_bus_grant_enable;
    wire [CNT_W-1:0] restart_len = ctrl_i.quick_recovery_select ?
                                   CNT_W'(QUICK_RESTART_CYCLES - 1) :
                                   CNT_W'(SLOW_RESTART_CYCLES - 1);
    wire strobe_on  = fme ? (core_i.opcode_fetch | core_i.int_ack | core_i.nmi_ack_first)
                          : core_i.interrupt_return_instruction_refetch;
    wire grant_d    = (state_d == ST_GRANTED) |
                      (req_act & ((state_d == ST_RUN) | (state_d == ST_HALT) |
                                  (state_d == ST_SLEEP)));
    wire wake_now     = (state_d == ST_RUN) & ~st_run;    // low-power state returns to run
    wire resume_d_nmi = wake_now & nmi_any;
    wire nmi_taken    = nmi_run | resume_d_nmi;            // pending nmi consumed now

    // next-state logic
    always_comb begin
        state_d = state_q;
        ret_d   = ret_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            ST_RUN: begin
                if (core_i.halt_exec) begin
                    state_d = ST_HALT;
                end else if (core_i.sleep_exec && sleep_mode) begin
                    state_d = ST_SLEEP;
                end else if (core_i.sleep_exec && stby_mode) begin
                    state_d = ST_STANDBY;
                end else if (core_i.sleep_exec) begin
                    state_d = ST_IDLE;
                end
            end
            ST_HALT, ST_SLEEP: begin
                if (wake_any) begin
                    state_d = ST_RUN;
                end
            end
            ST_IDLE: begin
                // bus request wins over a simultaneous wake
                if (lp_grant) begin
                    state_d = ST_GRANT_WAIT;
                    ret_d   = ST_IDLE;
                    cnt_d   = CNT_W'(IDLE_GRANT_EXTRA - 1);
                end else if (wake_any) begin
                    state_d = ST_RUN;
                end
            end
            ST_STANDBY: begin
                if (lp_grant) begin
                    state_d = ST_GRANT_WAIT;
                    ret_d   = ST_STANDBY;
                    cnt_d   = restart_len;
                end else if (nmi_any || ext_wake) begin
                    state_d = ST_RESTART;
                    cnt_d   = restart_len;
                end
            end
            ST_RESTART: begin
                if (!nmi_any && !ext_wake) begin
                    state_d = ST_STANDBY;
                end else if (cnt_done) begin
                    state_d = ST_RUN;
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            ST_GRANT_WAIT: begin
                if (!req_act) begin
                    state_d = ret_q;
                end else if (cnt_done) begin
                    state_d = ST_GRANTED;
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            ST_GRANTED: begin
                if (!req_act) begin
                    state_d = ret_q;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // pin synchronisers, first stage read only by the second
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            mreq_s1_q <= 3'h7;
            mreq_s2_q <= 3'h7;
            misc_s1_q <= 2'h3;
            misc_s2_q <= 2'h3;
            nmi_old_q <= 1'b1;
        end else if (ce_i) begin
            mreq_s1_q <= maskable_request_n_i;
            mreq_s2_q <= mreq_s1_q;
            misc_s1_q <= {bus_request_n_i, nmi_n_i};
            misc_s2_q <= misc_s1_q;
            nmi_old_q <= nmi_lvl;
        end
    end

    // operating mode register, fetch marker forced on by reset
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            operating_mode_control_q <= OPERATING_MODE_CONTROL_RESET;
        end else if (operating_mode_control_wr) begin
            operating_mode_control_q <= io_wdata_i;
        end
    end

    // state, count and nmi latch; reset leaves low power without counting
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_q    <= ST_RUN;
            ret_q      <= ST_IDLE;
            cnt_q      <= '0;
            nmi_pend_q <= 1'b0;
        end else if (ce_i) begin
            state_q    <= state_d;
            ret_q      <= ret_d;
            cnt_q      <= cnt_d;
            // a take consumes the oldest request; a new edge in that cycle stays pending
            nmi_pend_q <= nmi_taken ? (nmi_edge & nmi_pend_q) : (nmi_edge | nmi_pend_q);
        end
    end

    // wake pulses, vector and return address
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            resume_q    <= 1'b0;
            take_q      <= 1'b0;
            nmi_take_q  <= 1'b0;
            vector_q    <= 16'h0000;
            resume_pc_q <= 16'h0000;
        end else if (ce_i) begin
            resume_q   <= wake_now;
            take_q     <= wake_now & take_int;
            nmi_take_q <= nmi_run | resume_d_nmi;
            if (nmi_run || resume_d_nmi) begin
                vector_q <= NMI_VECTOR;
            end
            if (st_run && (core_i.halt_exec || core_i.sleep_exec)) begin
                resume_pc_q <= core_i.next_pc;
            end
        end
    end

    // strobe and acknowledge; strobe held high outside run
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            strobe_n_q <= 1'b1;
            bus_ack_q  <= 1'b0;
        end else if (ce_i) begin
            strobe_n_q <= ~(strobe_on & st_run);
            bus_ack_q  <= grant_d;
        end
    end

    // outputs decoded from registered state; read data and refetch request from inputs
    assign io_rdata_o             = (io_rd_i && operating_mode_control_hit) ? operating_mode_control_q : 8'h00;
    assign first_cycle_strobe_n_o = strobe_n_q;
    assign halt_n_o               = ~(waiting | (state_q == ST_RESTART) |
                                      (state_q == ST_GRANT_WAIT) |
                                      (state_q == ST_GRANTED));
    assign bus_ack_n_o            = ~bus_ack_q;
    assign core_clock_en_o        = st_run | (state_q == ST_HALT);
    assign dma_clock_en_o         = st_run | (state_q == ST_HALT);
    assign refresh_en_o           = st_run | (state_q == ST_HALT);
    assign system_clock_run_o     = st_run | (state_q == ST_HALT) |
                                    (state_q == ST_SLEEP) | (state_q == ST_GRANTED);
    assign bus_hold_high_o        = (state_q == ST_SLEEP) & ~bus_ack_q;
    assign resume_o               = resume_q;
    assign take_interrupt_o       = take_q;
    assign nmi_take_o             = nmi_take_q;
    assign vector_o               = vector_q;
    assign resume_pc_o            = resume_pc_q;
    // single fetch when marker on, so refetch only asked when off
    assign interrupt_return_instruction_refetch_o         = core_i.interrupt_return_instruction_fetched & ~fme;
    assign fetch_marker_enable_o  = fme;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i || !ce_i);

    sequence s_idle_req;
        (state_q == ST_IDLE) && lp_grant;
    endsequence

    a_fme_reset_one: assert property (disable iff (1'b0) srst_i |=> fme)
        else $error("fetch marker not set by reset");
    a_strobe_on_fetch: assert property (st_run && fme && core_i.opcode_fetch
        |=> !first_cycle_strobe_n_o)
        else $error("strobe missing on opcode fetch");
    a_strobe_off_fme: assert property (!fme && !core_i.interrupt_return_instruction_refetch
        |=> first_cycle_strobe_n_o)
        else $error("strobe driven with marker off");
    a_halt_resume_pc: assert property (st_run && core_i.halt_exec
        |=> (state_q == ST_HALT) && resume_pc_o == $past(core_i.next_pc) && !halt_n_o)
        else $error("halt entry or return address wrong");
    a_sleep_bus_high: assert property ((state_q == ST_SLEEP) && !bus_ack_q
        |-> bus_hold_high_o && !halt_n_o && !core_clock_en_o)
        else $error("sleep outputs wrong");
    a_idle_grant_delay: assert property (s_idle_req ##1 req_act [*8]
        |=> !bus_ack_n_o)
        else $error("idle grant not after eight cycles");
    a_idle_grant_early: assert property (s_idle_req |=> bus_ack_n_o [*8])
        else $error("idle grant too early");
    a_idle_release: assert property ((state_q == ST_GRANTED) && !req_act
        && ret_q == ST_IDLE |=> (state_q == ST_IDLE) && !system_clock_run_o)
        else $error("release did not return to idle");
    a_restart_abort: assert property ((state_q == ST_RESTART) && !nmi_any
        && !ext_wake |=> state_q == ST_STANDBY)
        else $error("restart not aborted");
    a_restart_load: assert property ((state_q == ST_STANDBY) && ext_wake && !lp_grant
        && ctrl_i.quick_recovery_select |=> cnt_q == CNT_W'(QUICK_RESTART_CYCLES - 1))
        else $error("quick restart count wrong");
    a_stby_grant_load: assert property ((state_q == ST_STANDBY) && lp_grant
        |=> (state_q == ST_GRANT_WAIT) && cnt_q == $past(restart_len))
        else $error("standby grant count wrong");
    a_wake_continue: assert property (waiting && (state_q != ST_STANDBY) && wake_any
        && !nmi_any && !global_interrupt_flag_i && !lp_grant
        |=> resume_o && !take_interrupt_o)
        else $error("wake with flag zero took interrupt");
    a_nmi_vector: assert property (nmi_run |=> nmi_take_o && vector_o == NMI_VECTOR)
        else $error("nmi vector wrong");
    a_reset_exit: assert property (disable iff (1'b0) srst_i |=> st_run)
        else $error("reset did not leave low power");

endmodule : cpu_low_power_mode_control

//--- verification/far_side.sv
/* far-side model: external interrupt sources and bus master on the pins.
   assumes the bench calls its tasks from one process; lines idle high. */
module far_side (
    input  wire logic       mclk_i,   // system clock
    output logic      [2:0] irq_n_o,  // maskable pins, low active
    output logic            nmi_n_o,  // nmi pin, falling edge counts
    output logic            breq_n_o  // bus request pin, low active
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        irq_n_o = 3'h7;
        nmi_n_o = 1'b1;
        breq_n_o = 1'b1;
    end
    // request held as long as told, must cover the restart count
    task automatic irq(input int k, input bit on);
        @(posedge mclk_i);
        irq_n_o[k] <= !on;
    endtask : irq
    // release ends the grant, device drops back to its low-power state
    task automatic breq(input bit on);
        @(posedge mclk_i);
        breq_n_o <= !on;
    endtask : breq
    task automatic nmi(input bit on);
        @(posedge mclk_i);
        nmi_n_o <= !on;
    endtask : nmi
endmodule : far_side

//--- verification/cpu_low_power_mode_control_tb.sv
/* bench for the low-power controller: register, strobe, halt, sleep, idle, standby.
   assumes the far_side model for pins; slow restart count shortened to 100. */
module cpu_low_power_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lpm_pkg::*;
    localparam int SLOW = 100;  // short slow restart keeps the run brief
    logic mclk_i = 0, srst_i = 1, io_wr = 0, io_rd = 0, flag = 0, ce = 1;
    logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, rdata;
    core_status_t cs = '0;  // core cycle status
    cpu_control_t ctl = '0;  // control bits
    logic [3:0] oc_req = 4'h0, oc_en = 4'h1;  // only on-chip source 0 enabled
    logic [2:0] irq_n, mk_en = 3'h7;
    logic nmi_n, breq_n, strb_n, halt_n, back_n, ccen, clk_run, rfen, hold, resume, take, refetch;
    logic dma_en, nmi_tk, fme;
    logic [15:0] vec, rpc;
    int failures = 0, checks = 0, cyc = 0, n_run, n_idle, n_q, n_s, n;
    always #10 mclk_i = ~mclk_i;
    far_side i_far (.mclk_i(mclk_i), .irq_n_o(irq_n), .nmi_n_o(nmi_n), .breq_n_o(breq_n));
    cpu_low_power_mode_control #(.ONCHIP_SOURCES(4), .SLOW_RESTART_CYCLES(SLOW)) i_dut (
        .mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce), .io_addr_i(io_addr), .io_wr_i(io_wr),
        .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(rdata), .core_i(cs), .ctrl_i(ctl),
        .global_interrupt_flag_i(flag), .onchip_req_i(oc_req), .onchip_en_i(oc_en),
        .maskable_en_i(mk_en), .maskable_request_n_i(irq_n), .nmi_n_i(nmi_n),
        .bus_request_n_i(breq_n), .first_cycle_strobe_n_o(strb_n), .halt_n_o(halt_n),
        .bus_ack_n_o(back_n), .core_clock_en_o(ccen), .dma_clock_en_o(dma_en),
        .system_clock_run_o(clk_run), .refresh_en_o(rfen), .bus_hold_high_o(hold),
        .resume_o(resume), .take_interrupt_o(take), .nmi_take_o(nmi_tk), .vector_o(vec),
        .resume_pc_o(rpc), .interrupt_return_instruction_refetch_o(refetch), .fetch_marker_enable_o(fme));
    task automatic report_and_stop;
        if (failures == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    // hang guard, whole run is a few hundred cycles
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] d);
        @(posedge mclk_i) {io_addr, io_wdata, io_wr} <= {OPERATING_MODE_CONTROL_ADDR, d, 1'b1};
        @(posedge mclk_i) io_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i) {io_addr, io_rd} <= {a, 1'b1};
        #1 chk("rdata", 16'(rdata), 16'(exp));
        @(posedge mclk_i) io_rd <= 1'b0;
    endtask : rd
    // one status cycle, then strobe is registered at the next edge; index 3 is the refetch
    task automatic strobe(input int i);
        @(posedge mclk_i) {cs.opcode_fetch, cs.int_ack, cs.nmi_ack_first, cs.interrupt_return_instruction_refetch} <=
            4'(8 >> i);
        @(posedge mclk_i) {cs.opcode_fetch, cs.int_ack, cs.nmi_ack_first, cs.interrupt_return_instruction_refetch} <=
            4'h0;
        #1;
    endtask : strobe
    task automatic interrupt_return_instruction(input logic exp);
        @(posedge mclk_i) cs.interrupt_return_instruction_fetched <= 1'b1;
        #1 chk("refetch", 16'(refetch), 16'(exp));
        @(posedge mclk_i) cs.interrupt_return_instruction_fetched <= 1'b0;
    endtask : interrupt_return_instruction
    task automatic exec(input bit h, input logic [15:0] pc);
        @(posedge mclk_i) {cs.halt_exec, cs.sleep_exec, cs.next_pc} <= {h, !h, pc};
        @(posedge mclk_i) {cs.halt_exec, cs.sleep_exec} <= 2'b00;
        #1 chk("halt_n", 16'(halt_n), 16'h0000);
    endtask : exec
    // cycles until resume pulse or bus grant, bounded
    task automatic wait_ev(output int c);
        c = 0;
        do begin
            @(posedge mclk_i);
            #1 c++;
        end while (resume !== 1'b1 && back_n !== 1'b0 && c < 600);
        if (c >= 600) failures++;  // a wait that never ends counts as a mismatch
    endtask : wait_ev
    initial begin
        repeat (5) @(posedge mclk_i);
        srst_i <= 1'b0;
        rd(OPERATING_MODE_CONTROL_ADDR, OPERATING_MODE_CONTROL_RESET);
        rd(8'h3F, 8'h00);
        for (int i = 0; i < 3; i++) begin
            strobe(i);
            chk("strobe", 16'(strb_n), 16'h0000);
        end
        interrupt_return_instruction(1'b0);
        wr(8'h00);
        strobe(0);
        chk("strobe_off", 16'(strb_n), 16'h0001);
        interrupt_return_instruction(1'b1);
        strobe(3);
        chk("strobe_refetch", 16'(strb_n), 16'h0000);
        @(posedge mclk_i) ce <= 1'b0;
        wr(8'hFF);
        ce <= 1'b1;
        #1 chk("freeze", 16'(fme), 16'h0000);
        wr(8'h80);
        exec(1'b1, 16'h1234);
        i_far.breq(1'b1);
        wait_ev(n_run);
        i_far.breq(1'b0);
        repeat (5) @(posedge mclk_i);
        {flag, oc_req} <= 5'h11;
        wait_ev(n);
        chk("halt_take", 16'(take), 16'h0001);
        chk("halt_pc", rpc, 16'h1234);
        @(posedge mclk_i) {oc_req, mk_en} <= 7'h10;  // source 1 raised but disabled
        exec(1'b0, 16'h2000);
        chk("bus_hold", 16'({hold, ccen, dma_en, clk_run, rfen}), 16'h0012);
        i_far.irq(0, 1'b1);
        repeat (10) @(posedge mclk_i);
        #1 chk("no_wake", 16'(halt_n), 16'h0000);
        @(posedge mclk_i) {flag, mk_en} <= 4'h7;
        wait_ev(n);
        chk("sleep_take", 16'(take), 16'h0000);
        chk("sleep_pc", rpc, 16'h2000);
        i_far.irq(0, 1'b0);
        @(posedge mclk_i) ctl <= 4'b1010;
        exec(1'b0, 16'h3000);
        i_far.breq(1'b1);
        wait_ev(n_idle);
        chk("idle_grant", 16'(n_idle - n_run), 16'h0008);
        i_far.breq(1'b0);
        repeat (5) @(posedge mclk_i);
        #1 chk("idle_stop", 16'({halt_n, clk_run}), 16'h0000);
        i_far.nmi(1'b1);
        wait_ev(n);
        chk("nmi_take", 16'(take), 16'h0001);
        chk("nmi_pulse", 16'(nmi_tk), 16'h0001);
        i_far.nmi(1'b0);
        repeat (2) @(posedge mclk_i) {ctl, flag} <= 5'b11011;
        chk("nmi_vec", vec, NMI_VECTOR);
        exec(1'b0, 16'h4000);
        i_far.irq(1, 1'b1);
        wait_ev(n_q);
        chk("stby_take", 16'(take), 16'h0001);
        i_far.irq(1, 1'b0);
        @(posedge mclk_i) {ctl, flag} <= 5'b10010;
        exec(1'b0, 16'h5000);
        i_far.irq(1, 1'b1);
        repeat (10) @(posedge mclk_i);
        i_far.irq(1, 1'b0);
        repeat (150) @(posedge mclk_i);
        #1 chk("stay_stby", 16'(halt_n), 16'h0000);
        i_far.irq(1, 1'b1);
        wait_ev(n_s);
        chk("stby_cont", 16'(take), 16'h0000);
        chk("stby_pc", rpc, 16'h5000);
        chk("restart_len", 16'(n_s - n_q), 16'(SLOW - QUICK_RESTART_CYCLES));
        report_and_stop();
    end
endmodule : cpu_low_power_mode_control_tb
